/* File: irq_halt_pkg.sv */
`default_nettype none
package irq_halt_pkg;

    // Restart targets and acknowledge stretching.
    localparam logic [15:0] NMI_RESTART_ADDR = 16'h0066;
    localparam logic [15:0] MODE1_RESTART_ADDR = 16'h0038;
    localparam logic [1:0] ACK_AUTO_WAITS = 2'h2;
    localparam logic [1:0] NO_WAITS = 2'h0;

    // Maskable response modes and values after reset.
    localparam logic [1:0] IRQ_MODE_0 = 2'h0;
    localparam logic [1:0] IRQ_MODE_1 = 2'h1;
    localparam logic [1:0] IRQ_MODE_RESET = 2'h0;
    localparam logic IFF_RESET = 1'b0;
    localparam logic [2:0] SYNC_RESET = 3'h7;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HALT,
        ST_ACK
    } ctl_state_t;

    // One-cycle strobes from the instruction decoder, on the final clock.
    typedef struct packed {
        logic halt;
        logic enable_irq_instr;
        logic mask_irq_instr;
        logic nonmaskable_return_instr;
        logic copy_vector_base_to_acc;
        logic copy_refresh_ctr_to_acc;
        logic mode_write;
        logic [1:0] mode_value;
    } instr_strobes_t;

    // Machine cycle timing from the sequencer.
    typedef struct packed {
        logic fetch_t4;
        logic instr_last_clk;
        logic ack_done;
    } fetch_timing_t;

    // Acknowledge cycle description handed to the sequencer.
    typedef struct packed {
        logic valid;
        logic nmi;
        logic use_io_strobe;
        logic mem_read_ignored;
        logic exec_bus_instr;
        logic push_pc;
        logic [1:0] wait_states;
        logic [15:0] restart_addr;
    } ack_info_t;

    localparam ack_info_t ACK_RESET = '0;

endpackage
`default_nettype wire

/* File: pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [2:0] pins_async,
    output logic [2:0] pins_sync
);
    import irq_halt_pkg::*;

    logic [2:0] meta_ff;
    logic [2:0] stable_ff;

    // Two flops per pin; the pins idle high, so reset to high.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= SYNC_RESET;
            stable_ff <= SYNC_RESET;
        end else begin
            meta_ff <= pins_async;
            stable_ff <= meta_ff;
        end
    end

    assign pins_sync = stable_ff;
endmodule // pin_sync
`default_nettype wire

/* File: irq_enable_pair.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_enable_pair (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic set_both,
    input wire logic clear_both,
    input wire logic clear_live,
    input wire logic restore_live,
    output logic live,
    output logic saved
);
    import irq_halt_pkg::*;

    logic live_ff;
    logic saved_ff;

    // Acceptance clears win over instruction effects in the same cycle.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            live_ff <= IFF_RESET;
            saved_ff <= IFF_RESET;
        end else if (clear_both) begin
            live_ff <= 1'b0;
            saved_ff <= 1'b0;
        end else if (clear_live) begin
            live_ff <= 1'b0;
        end else if (set_both) begin
            live_ff <= 1'b1;
            saved_ff <= 1'b1;
        end else if (restore_live) begin
            live_ff <= saved_ff;
        end
    end

    assign live = live_ff;
    assign saved = saved_ff;
endmodule // irq_enable_pair
`default_nettype wire

/* File: cpu_interrupt_halt_control.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_halt_control (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic irq_req_n,
    input wire logic nmi_req_n,
    input wire logic bus_hold_request_n,
    input wire irq_halt_pkg::fetch_timing_t timing,
    input wire irq_halt_pkg::instr_strobes_t instrs,
    output logic halt_ack_n,
    output logic force_nop,
    output logic irq_enable_live,
    output logic irq_enable_saved,
    output logic [1:0] irq_mode,
    output logic parity_load,
    output logic parity_value,
    output irq_halt_pkg::ack_info_t ack
);
    import irq_halt_pkg::*;

    logic [2:0] pins_sync;
    logic irq_active;
    logic nmi_level;
    logic bus_held;
    logic nmi_prev_ff;
    logic nmi_pend_ff;
    logic nmi_fall;
    ctl_state_t state_ff;
    ctl_state_t nxt_state;
    logic exit_armed_ff;
    logic exit_nmi_ff;
    logic sample_point;
    logic take_nmi;
    logic take_int;
    logic take_any;
    logic go_ack;
    logic go_ack_nmi;
    logic [1:0] mode_ff;
    logic halt_ack_n_ff;
    logic force_nop_ff;
    logic parity_load_ff;
    logic parity_value_ff;
    ack_info_t ack_ff;
    ack_info_t nxt_ack;
    logic iff_live;
    logic iff_saved;

    // Pins come from outside the clock domain; no logic sees them
    // until they have passed both synchroniser flops.
    pin_sync i_pin_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .pins_async({irq_req_n, nmi_req_n, bus_hold_request_n}),
        .pins_sync(pins_sync)
    );

    // All request lines are active low.
    assign irq_active = ~pins_sync[2];
    assign nmi_level = ~pins_sync[1];
    assign bus_held = ~pins_sync[0];

    // The nonmaskable line is edge sensitive, so a falling edge is
    // remembered until acceptance even if the line rises again.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            nmi_prev_ff <= 1'b0;
        end else begin
            nmi_prev_ff <= nmi_level;
        end
    end

    assign nmi_fall = nmi_level & ~nmi_prev_ff;

    // A new edge in the acceptance cycle wins over the clear, so a
    // second request arriving just then is not lost.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            nmi_pend_ff <= 1'b0;
        end else if (nmi_fall) begin
            nmi_pend_ff <= 1'b1;
        end else if (take_nmi) begin
            nmi_pend_ff <= 1'b0;
        end
    end

    // Sampling point: the T4 edge of each halt fetch, otherwise the
    // final clock of an instruction. A halt instruction itself is not
    // a sampling point; its first halt fetch T4 is.
    always_comb begin
        sample_point = 1'b0;
        if (state_ff == ST_HALT) begin
            sample_point = timing.fetch_t4 & ~exit_armed_ff;
        end else if (state_ff == ST_RUN) begin
            sample_point = timing.instr_last_clk & ~instrs.halt;
        end
    end

    // Nonmaskable taken when sampled unless the bus is held; maskable needs the live
    // flop, must not fall at the end of the enabling or disabling
    // instruction, and yields to the nonmaskable line.
    assign take_nmi = sample_point & nmi_pend_ff & ~bus_held;
    assign take_int = sample_point & irq_active & ~bus_held
        & iff_live
        & ~instrs.enable_irq_instr
        & ~instrs.mask_irq_instr
        & ~nmi_pend_ff;
    assign take_any = take_nmi | take_int;

    // In halt the acceptance is armed at T4 and acted on one edge later.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            exit_armed_ff <= 1'b0;
            exit_nmi_ff <= 1'b0;
        end else if (state_ff == ST_HALT && take_any) begin
            exit_armed_ff <= 1'b1;
            exit_nmi_ff <= take_nmi;
        end else begin
            exit_armed_ff <= 1'b0;
            exit_nmi_ff <= 1'b0;
        end
    end

    // Entry to the acknowledge cycle and which kind it is.
    always_comb begin
        go_ack = 1'b0;
        go_ack_nmi = 1'b0;
        if (state_ff == ST_RUN) begin
            go_ack = take_any;
            go_ack_nmi = take_nmi;
        end else if (state_ff == ST_HALT) begin
            go_ack = exit_armed_ff;
            go_ack_nmi = exit_nmi_ff;
        end
    end

    // Control sequence. Nothing here counts time, so a stopped clock
    // simply holds every flop and the block resumes on the next edge.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN: begin
                if (instrs.halt) begin
                    nxt_state = ST_HALT;
                end else if (go_ack) begin
                    nxt_state = ST_ACK;
                end
            end
            ST_HALT: begin
                if (go_ack) begin
                    nxt_state = ST_ACK;
                end
            end
            ST_ACK: begin
                if (timing.ack_done) begin
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Halt acknowledge and forced no-op follow the next state so they
    // change on the same edge as the halt state itself.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            halt_ack_n_ff <= 1'b1;
            force_nop_ff <= 1'b0;
        end else begin
            halt_ack_n_ff <= (nxt_state != ST_HALT);
            force_nop_ff <= (nxt_state == ST_HALT);
        end
    end

    // Mode field, written only by the mode select instruction.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mode_ff <= IRQ_MODE_RESET;
        end else if (instrs.mode_write) begin
            mode_ff <= instrs.mode_value;
        end
    end

    // Describe the acknowledge cycle from its kind and the mode field.
    // Mode 2 table handling lives elsewhere; here it only gets the
    // I/O strobe and the automatic waits.
    always_comb begin
        nxt_ack = ack_ff;
        if (go_ack) begin
            nxt_ack = ACK_RESET;
            nxt_ack.valid = 1'b1;
            if (go_ack_nmi) begin
                nxt_ack.nmi = 1'b1;
                nxt_ack.mem_read_ignored = 1'b1;
                nxt_ack.push_pc = 1'b1;
                nxt_ack.wait_states = NO_WAITS;
                nxt_ack.restart_addr = NMI_RESTART_ADDR;
            end else begin
                nxt_ack.use_io_strobe = 1'b1;
                nxt_ack.wait_states = ACK_AUTO_WAITS;
                if (mode_ff == IRQ_MODE_0) begin
                    nxt_ack.exec_bus_instr = 1'b1;
                end else if (mode_ff == IRQ_MODE_1) begin
                    nxt_ack.push_pc = 1'b1;
                    nxt_ack.restart_addr = MODE1_RESTART_ADDR;
                end
            end
        end else if (state_ff == ST_ACK && timing.ack_done) begin
            nxt_ack = ACK_RESET;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff <= ACK_RESET;
        end else begin
            ack_ff <= nxt_ack;
        end
    end

    // Enable flops; acceptance is applied on the sampling edge itself
    // so no second request can slip in behind it.
    irq_enable_pair i_irq_enable_pair (
        .mclk(mclk),
        .reset_n(reset_n),
        .set_both(instrs.enable_irq_instr),
        .clear_both(instrs.mask_irq_instr | take_int),
        .clear_live(take_nmi),
        .restore_live(instrs.nonmaskable_return_instr),
        .live(iff_live),
        .saved(iff_saved)
    );

    // Parity flag copy for the two accumulator loads.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            parity_load_ff <= 1'b0;
            parity_value_ff <= 1'b0;
        end else begin
            parity_load_ff <= instrs.copy_vector_base_to_acc
                | instrs.copy_refresh_ctr_to_acc;
            parity_value_ff <= iff_saved;
        end
    end

    assign halt_ack_n = halt_ack_n_ff;
    assign force_nop = force_nop_ff;
    assign irq_enable_live = iff_live;
    assign irq_enable_saved = iff_saved;
    assign irq_mode = mode_ff;
    assign parity_load = parity_load_ff;
    assign parity_value = parity_value_ff;
    assign ack = ack_ff;
endmodule // cpu_interrupt_halt_control
`default_nettype wire

/* File: irq_halt_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_halt_chk (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic irq_req_n,
    input wire logic nmi_req_n,
    input wire logic bus_hold_request_n,
    input wire irq_halt_pkg::fetch_timing_t timing,
    input wire irq_halt_pkg::instr_strobes_t instrs,
    input wire logic halt_ack_n,
    input wire logic force_nop,
    input wire logic irq_enable_live,
    input wire logic irq_enable_saved,
    input wire logic [1:0] irq_mode,
    input wire logic parity_load,
    input wire logic parity_value,
    input wire irq_halt_pkg::ack_info_t ack
);
    import irq_halt_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Halt state, its fetches and its exit, which only a T4 sample may trigger.
    a_halt_nop_agree: assert property (halt_ack_n == !force_nop)
        else $error("halt acknowledge and forced no-op disagree");
    a_halt_entry: assert property (instrs.halt && halt_ack_n && !ack.valid
        |=> !halt_ack_n) else $error("halt not entered");
    a_halt_holds: assert property (!halt_ack_n && !timing.fetch_t4
        && !$past(timing.fetch_t4) |=> !halt_ack_n)
        else $error("halt left without a sample");
    a_halt_exit_time: assert property ($rose(halt_ack_n)
        |-> $past(timing.fetch_t4, 2) && ack.valid) else $error("halt exit mistimed");
    // The acknowledge description must not move while the sequencer uses it.
    a_ack_stands: assert property (ack.valid && !timing.ack_done |=> $stable(ack))
        else $error("acknowledge fields changed");
    a_ack_ends: assert property (ack.valid && timing.ack_done |=> !ack.valid)
        else $error("acknowledge did not end");
    // Enable flip-flop side effects.
    a_enable_sets: assert property (instrs.enable_irq_instr |=>
        (irq_enable_live && irq_enable_saved) || (ack.valid && ack.nmi))
        else $error("enable instruction did not set both flops");
    a_mask_clears: assert property (instrs.mask_irq_instr
        |=> !irq_enable_live && !irq_enable_saved)
        else $error("mask instruction did not clear both flops");
    a_irq_take_clr: assert property ($rose(ack.valid) && !ack.nmi
        |-> !irq_enable_live && !irq_enable_saved
        && ($past(irq_enable_live) || $past(irq_enable_live, 2)))
        else $error("maskable acceptance wrong");
    a_nmi_take: assert property ($rose(ack.valid) && ack.nmi
        |-> !irq_enable_live && $stable(irq_enable_saved)) else $error("nmi flops wrong");
    a_nmi_fields: assert property (ack.valid && ack.nmi
        |-> ack.push_pc && ack.mem_read_ignored && !ack.use_io_strobe
        && ack.restart_addr == NMI_RESTART_ADDR) else $error("nmi fields");
    a_irq_fields: assert property (ack.valid && !ack.nmi
        |-> ack.use_io_strobe && ack.wait_states == ACK_AUTO_WAITS) else $error("irq fields");
    a_mode1_fields: assert property (ack.valid && !ack.nmi && irq_mode == IRQ_MODE_1
        |-> ack.push_pc && ack.restart_addr == MODE1_RESTART_ADDR) else $error("mode 1 fields");
    a_parity_copy: assert property (instrs.copy_vector_base_to_acc
        || instrs.copy_refresh_ctr_to_acc |=> parity_load
        && parity_value == $past(irq_enable_saved)) else $error("parity copy");
    a_return_restore: assert property (instrs.nonmaskable_return_instr
        |=> irq_enable_live == $past(irq_enable_saved)) else $error("restore");
    a_mode_field: assert property (1'b1 |=> irq_mode ==
        ($past(instrs.mode_write) ? $past(instrs.mode_value) : $past(irq_mode)))
        else $error("mode field");
    c_halt_exit: cover property ($rose(halt_ack_n));
    c_nmi_ack: cover property ($rose(ack.valid) && ack.nmi);
    c_irq_ack: cover property ($rose(ack.valid) && !ack.nmi);
endmodule // irq_halt_chk

bind cpu_interrupt_halt_control irq_halt_chk i_irq_halt_chk (
    .mclk(mclk), .reset_n(reset_n), .irq_req_n(irq_req_n), .nmi_req_n(nmi_req_n),
    .bus_hold_request_n(bus_hold_request_n), .timing(timing), .instrs(instrs),
    .halt_ack_n(halt_ack_n), .force_nop(force_nop), .irq_enable_live(irq_enable_live),
    .irq_enable_saved(irq_enable_saved), .irq_mode(irq_mode), .parity_load(parity_load),
    .parity_value(parity_value), .ack(ack)
);
`default_nettype wire

/* File: irq_peripheral_model.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_peripheral_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic irq_go,
    input wire logic nmi_go,
    input wire irq_halt_pkg::ack_info_t ack,
    output logic irq_req_n,
    output logic nmi_req_n
);
    import irq_halt_pkg::*;
    logic [2:0] nmi_cnt_ff;

    // The maskable line stays low until serviced, as a real peripheral keeps asking.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_req_n <= 1'b1;
        end else if (irq_go) begin
            irq_req_n <= 1'b0;
        end else if (ack.valid && !ack.nmi) begin
            irq_req_n <= 1'b1;
        end
    end

    // The nonmaskable line is a short low pulse; the counter returns it high after four cycles.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            nmi_cnt_ff <= 3'h0;
        end else if (nmi_go) begin
            nmi_cnt_ff <= 3'h4;
        end else if (nmi_cnt_ff != 3'h0) begin
            nmi_cnt_ff <= nmi_cnt_ff - 3'h1;
        end
    end
    assign nmi_req_n = (nmi_cnt_ff == 3'h0);
endmodule // irq_peripheral_model
`default_nettype wire

/* File: cpu_interrupt_halt_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_halt_control_tb;
    import irq_halt_pkg::*;
    localparam instr_strobes_t S_HALT = 9'h100;
    localparam instr_strobes_t S_EN = 9'h080;
    localparam instr_strobes_t S_MASK = 9'h040;
    localparam instr_strobes_t S_NMRET = 9'h020;
    localparam instr_strobes_t S_CVB = 9'h010;
    localparam instr_strobes_t S_CRC = 9'h008;
    localparam instr_strobes_t S_MODE1 = 9'h005;
    localparam fetch_timing_t T_T4 = 3'h4;
    localparam fetch_timing_t T_LAST = 3'h2;
    localparam fetch_timing_t T_DONE = 3'h1;
    logic mclk = 1'b0;
    logic run_clk = 1'b1;
    logic reset_n = 1'b0;
    logic bus_hold_request_n = 1'b1;
    logic irq_go = 1'b0;
    logic nmi_go = 1'b0;
    logic irq_req_n, nmi_req_n, halt_ack_n, force_nop, irq_enable_live, irq_enable_saved;
    logic parity_load, parity_value;
    logic [1:0] irq_mode;
    fetch_timing_t timing = '0;
    instr_strobes_t instrs = '0;
    ack_info_t ack;
    int bad_count = 0;
    int n_checks = 0;

    // The clock can be parked at its current level to model a power-down.
    initial begin
        forever #4 if (run_clk) mclk = ~mclk;
    end

    cpu_interrupt_halt_control i_cpu_interrupt_halt_control (.mclk(mclk), .reset_n(reset_n),
        .irq_req_n(irq_req_n), .nmi_req_n(nmi_req_n), .bus_hold_request_n(bus_hold_request_n),
        .timing(timing), .instrs(instrs), .halt_ack_n(halt_ack_n), .force_nop(force_nop),
        .irq_enable_live(irq_enable_live), .irq_enable_saved(irq_enable_saved),
        .irq_mode(irq_mode), .parity_load(parity_load), .parity_value(parity_value), .ack(ack));
    irq_peripheral_model i_irq_peripheral_model (.mclk(mclk), .reset_n(reset_n),
        .irq_go(irq_go), .nmi_go(nmi_go), .ack(ack), .irq_req_n(irq_req_n),
        .nmi_req_n(nmi_req_n));

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle strobe; outputs are read after the sampling edge has settled.
    task automatic pulse(input instr_strobes_t s, input fetch_timing_t t);
        @(posedge mclk);
        instrs <= s;
        timing <= t;
        @(posedge mclk);
        instrs <= '0;
        timing <= '0;
        #1;
    endtask

    // Pins pass a two-flop synchroniser, so allow a few edges before sampling.
    task automatic req(input logic i, input logic n);
        @(posedge mclk);
        irq_go <= i;
        nmi_go <= n;
        @(posedge mclk);
        irq_go <= 1'b0;
        nmi_go <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    task automatic end_ack();
        pulse('0, T_DONE);
        chk("ack_end", ack.valid, 1'b0);
    endtask

    task automatic t_flops();
        chk("live_rst", irq_enable_live, 1'b0);
        chk("saved_rst", irq_enable_saved, 1'b0);
        chk("mode_rst", irq_mode, IRQ_MODE_0);
        pulse(S_EN, '0);
        chk("en_both", {irq_enable_live, irq_enable_saved}, 2'h3);
        pulse(S_CRC, '0);
        chk("par_set", {parity_load, parity_value}, 2'h3);
        pulse(S_MASK, '0);
        chk("mask_both", {irq_enable_live, irq_enable_saved}, 2'h0);
        pulse(S_CVB, '0);
        chk("par_clr", {parity_load, parity_value}, 2'h2);
    endtask

    // Refusals first, then a mode 0 acceptance of the same pending request.
    task automatic t_masked();
        req(1'b1, 1'b0);
        pulse('0, T_LAST);
        chk("masked", ack.valid, 1'b0);
        @(posedge mclk);
        bus_hold_request_n <= 1'b0;
        pulse(S_EN, '0);
        repeat (3) @(posedge mclk);
        pulse('0, T_LAST);
        chk("bus_held", ack.valid, 1'b0);
        @(posedge mclk);
        bus_hold_request_n <= 1'b1;
        repeat (3) @(posedge mclk);
        pulse(S_EN, T_LAST);
        chk("en_delay", ack.valid, 1'b0);
        pulse('0, T_LAST);
        chk("m0_valid", {ack.valid, ack.nmi, ack.use_io_strobe}, 3'h5);
        chk("m0_exec", ack.exec_bus_instr, 1'b1);
        chk("m0_waits", ack.wait_states, ACK_AUTO_WAITS);
        chk("m0_flops", {irq_enable_live, irq_enable_saved}, 2'h0);
        end_ack();
    endtask

    task automatic t_mode1();
        pulse(S_MODE1, '0);
        chk("mode1", irq_mode, IRQ_MODE_1);
        pulse(S_EN, '0);
        req(1'b1, 1'b0);
        pulse('0, T_LAST);
        chk("md1_valid", {ack.valid, ack.push_pc, ack.wait_states}, {2'h3, ACK_AUTO_WAITS});
        chk("md1_addr", ack.restart_addr, MODE1_RESTART_ADDR);
        end_ack();
    endtask

    task automatic t_nmi();
        pulse(S_EN, '0);
        req(1'b0, 1'b1);
        pulse('0, T_LAST);
        chk("nmi_valid", {ack.valid, ack.nmi, ack.mem_read_ignored}, 3'h7);
        chk("nmi_addr", ack.restart_addr, NMI_RESTART_ADDR);
        chk("nmi_flops", {irq_enable_live, irq_enable_saved}, 2'h1);
        end_ack();
        pulse(S_NMRET, '0);
        chk("nm_return", irq_enable_live, 1'b1);
    endtask

    // Halt with a clock stop in the middle, then both requests at one T4.
    task automatic t_halt();
        pulse(S_HALT, '0);
        chk("halted", {halt_ack_n, force_nop}, 2'h1);
        pulse('0, T_T4);
        run_clk = 1'b0;
        #100;
        chk("frozen", {halt_ack_n, force_nop, irq_enable_live}, 3'h3);
        run_clk = 1'b1;
        pulse('0, T_T4);
        chk("resume", halt_ack_n, 1'b0);
        req(1'b1, 1'b1);
        pulse('0, T_T4);
        chk("armed", {halt_ack_n, irq_enable_live}, 2'h0);
        @(posedge mclk);
        #1;
        chk("exit", {halt_ack_n, ack.valid}, 2'h3);
        chk("nmi_first", ack.nmi, 1'b1);
        end_ack();
    endtask

    task automatic conclude();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // A hang anywhere counts as a mismatch.
    initial begin
        #100000;
        bad_count++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        t_flops();
        t_masked();
        t_mode1();
        t_nmi();
        t_halt();
        conclude();
    end
endmodule // cpu_interrupt_halt_control_tb
`default_nettype wire
